// [hdl/lbt_pkg.sv]
/*
  Package for the loopback and pattern test control block: modes, lamp
  timing and the 511-bit sequence constants.
  Assumes a 100 MHz clock and a bit strobe from the line side.
*/
package lbt_pkg;
  localparam int unsigned LBT_CLK_MHZ = 100;
  // Lamp check length and error window, in milliseconds
  localparam int unsigned LBT_FLASH_MS = 200;
  localparam int unsigned LBT_WINDOW_MS = 250;
  localparam int unsigned LBT_FLASH_CYC = LBT_FLASH_MS * 1000 * LBT_CLK_MHZ;
  localparam int unsigned LBT_WINDOW_CYC = LBT_WINDOW_MS * 1000 * LBT_CLK_MHZ;
  // Sequence: 9-bit register, taps 9 and 5, period 511
  localparam int unsigned LBT_PRBS_LEN = 9;
  localparam logic [8:0] LBT_PRBS_SEED = 9'h1FF;
  // Correct bits in a row that declare the checker locked
  localparam logic [3:0] LBT_LOCK_BITS = 4'hA;
  // Errors per window at or above which errors count as continuous
  localparam logic [15:0] LBT_CONT_ERRS = 16'h0040;
  typedef enum logic [1:0] {
    LBT_PATH_NORMAL,
    LBT_PATH_ANALOG,
    LBT_PATH_DIGITAL
  } lbt_path_t;
  typedef enum logic [1:0] {
    LBT_LAMP_IDLE,
    LBT_LAMP_FLASH,
    LBT_LAMP_RUN
  } lbt_lamp_t;
endpackage : lbt_pkg

// [hdl/lbt_prbs.sv]
/*
  511-bit pseudo-random generator and checker, stepped by a bit strobe.
  Assumes the strobe and received bit are synchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module lbt_prbs
  import lbt_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic bit_strobe,
  input wire logic rx_bit,
  output logic tx_bit,
  output logic locked,
  output logic bit_error
);
  logic [8:0] gen_reg, gen_next;
  logic [8:0] chk_reg, chk_next;
  logic [3:0] good_reg, good_next;
  logic locked_reg, locked_next;
  logic err_reg, err_next;
  wire logic expect_bit;
  wire logic mismatch;

  function automatic logic [8:0] lbt_step(input logic [8:0] s);
    lbt_step = {s[7:0], s[8] ^ s[4]};
  endfunction : lbt_step

  assign expect_bit = chk_reg[8] ^ chk_reg[4];
  assign mismatch = expect_bit != rx_bit;
  // The checker loads the line bits before and after lock, taking the phase from the line
  assign gen_next = !run ? LBT_PRBS_SEED :
                    bit_strobe ? lbt_step(gen_reg) : gen_reg;
  assign chk_next = !run ? LBT_PRBS_SEED :
                    bit_strobe ? {chk_reg[7:0], rx_bit} : chk_reg;
  assign good_next = !run ? 4'h0 :
                     (bit_strobe && mismatch && !locked_reg) ? 4'h0 :
                     (bit_strobe && !locked_reg) ? good_reg + 4'h1 : good_reg;
  assign locked_next = run && (locked_reg || good_next == LBT_LOCK_BITS);
  assign err_next = run && locked_reg && bit_strobe && mismatch; // [RQ14]

  always_ff @(posedge clock) begin
    if (reset) begin
      gen_reg <= LBT_PRBS_SEED;
      chk_reg <= LBT_PRBS_SEED;
      good_reg <= 4'h0;
      locked_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      gen_reg <= gen_next; // [RQ11]
      chk_reg <= chk_next; // [RQ11]
      good_reg <= good_next;
      locked_reg <= locked_next;
      err_reg <= err_next;
    end
  end

  assign tx_bit = gen_reg[8];
  assign locked = locked_reg;
  assign bit_error = err_reg;
endmodule : lbt_prbs
`default_nettype wire

// [hdl/lbt_loop_ctrl.sv]
/*
  Loopback and pattern test control for a line modem card.
  Assumes buttons, loopback requests and peer signals are asynchronous
  pins; line bits and bit strobe arrive on clock from the line coder.
*/
//
// Contract
// RQ1: Tester needs carrier forced or request-to-send high; the tester runs on the pattern test button alone, ungated.
// RQ2: Pattern test disconnects terminal from data path.
// RQ3: Local-line button or request enters analog loop.
// RQ4: Analog loop lights test and carrier lamps.
// RQ5: Carrier off when unforced and request-to-send low.
// RQ6: Far-loop button or request signals peer loop.
// RQ7: Any digital loop lights test lamp.
// RQ8: Near-echo button signals peer, loops receiver to transmitter.
// RQ9: Near-echo behaves like peer-requested remote loop.
// RQ10: Lamp flashes, then lit, blinking or dark.
// RQ11: Send and check the 511-bit sequence.
// RQ12: Digital loop loops data, clock; ready goes low.
// RQ13: Pattern test holds receive data, clear-to-send low.
// RQ14: Checker locks, compares, classifies errors per window.
`timescale 1ns/100ps
`default_nettype none
module lbt_loop_ctrl
  import lbt_pkg::*;
#(
  parameter int unsigned FLASH_CYC = LBT_FLASH_CYC,
  parameter int unsigned WINDOW_CYC = LBT_WINDOW_CYC
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic pattern_test_button,
  input wire logic local_line_loop_button,
  input wire logic far_loop_button,
  input wire logic near_echo_loop_button,
  input wire logic local_loop_request,
  input wire logic remote_loop_request,
  input wire logic local_loop_enable,
  input wire logic remote_loop_enable,
  input wire logic carrier_force,
  input wire logic request_to_send,
  input wire logic peer_loop_request,
  input wire logic line_signal_valid,
  input wire logic bit_strobe,
  input wire logic line_rx_data,
  input wire logic line_rx_clock,
  input wire logic dte_tx_data,
  input wire logic dte_tx_clock,
  output logic line_tx_data,
  output logic line_tx_clock,
  output logic analog_loop,
  output logic peer_loop_signal,
  output logic dte_rx_data,
  output logic clear_to_send,
  output logic data_set_ready,
  output logic carrier_detect,
  output logic test_lamp,
  output logic carrier_lamp,
  output logic error_lamp
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 12;
  logic [NSYNC-1:0] sync1_reg, sync2_reg;
  wire logic [NSYNC-1:0] pins;
  assign pins = {pattern_test_button, local_line_loop_button,
                 far_loop_button, near_echo_loop_button, local_loop_request,
                 remote_loop_request, carrier_force, request_to_send,
                 peer_loop_request, line_signal_valid, local_loop_enable,
                 remote_loop_enable};
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  wire logic pattern_test_button_s, ana_s, far_s, near_s, llr_s, rlr_s;
  wire logic force_s, rts_s, peer_s, valid_s, lle_s, rle_s;
  assign {pattern_test_button_s, ana_s, far_s, near_s, llr_s, rlr_s, force_s, rts_s,
          peer_s, valid_s, lle_s, rle_s} = sync2_reg;

  // ----------------------------------------------------------------
  // Loopback mode decode
  // ----------------------------------------------------------------
  wire logic want_analog, want_far, want_near, digital_loop;
  assign want_analog = ana_s || (lle_s && llr_s); // [RQ3]
  assign want_far = far_s || (rle_s && rlr_s); // [RQ6]
  // Near echo acts as if the peer had requested the loop
  assign want_near = near_s; // [RQ8] [RQ9]
  assign digital_loop = want_near || peer_s; // [RQ9] [RQ12]
  wire lbt_path_t path_next;
  assign path_next = digital_loop ? LBT_PATH_DIGITAL :
                     want_analog ? LBT_PATH_ANALOG : LBT_PATH_NORMAL;
  wire logic rts_ok;
  // Carrier only when forced or the terminal raises request-to-send
  assign rts_ok = force_s || rts_s; // [RQ1] [RQ5]

  // ----------------------------------------------------------------
  // Pattern tester
  // ----------------------------------------------------------------
  logic prbs_tx, prbs_locked, prbs_err;
  wire logic rx_bit_in;
  assign rx_bit_in = line_rx_data;
  lbt_prbs u_prbs (
    .clock(clock),
    .reset(reset),
    .run(pattern_test_button_s),
    .bit_strobe(bit_strobe),
    .rx_bit(rx_bit_in),
    .tx_bit(prbs_tx),
    .locked(prbs_locked),
    .bit_error(prbs_err)
  );

  // ----------------------------------------------------------------
  // Error lamp: check flash, then window classification
  // ----------------------------------------------------------------
  lbt_lamp_t lamp_reg, lamp_next;
  logic [31:0] tick_reg, tick_next;
  logic [15:0] errs_reg, errs_next;
  logic [1:0] class_reg, class_next;
  logic blink_reg, blink_next;
  wire logic tick_end;
  assign tick_end = tick_reg == 32'(WINDOW_CYC - 1);
  always_comb begin
    lamp_next = lamp_reg;
    tick_next = tick_reg + 32'h1;
    errs_next = errs_reg;
    class_next = class_reg;
    blink_next = blink_reg;
    case (lamp_reg)
      LBT_LAMP_IDLE: begin
        tick_next = 32'h0;
        class_next = 2'h0;
        // Blink phase restarts with each test
        blink_next = 1'b0;
        if (pattern_test_button_s) begin
          lamp_next = LBT_LAMP_FLASH; // [RQ10]
        end
      end
      LBT_LAMP_FLASH: begin
        if (tick_reg == 32'(FLASH_CYC - 1)) begin
          lamp_next = LBT_LAMP_RUN;
          tick_next = 32'h0;
          errs_next = 16'h0;
        end
      end
      LBT_LAMP_RUN: begin
        if (prbs_err && errs_reg != 16'hFFFF) begin
          errs_next = errs_reg + 16'h1;
        end
        // Loss of lock counts as continuous error
        if (tick_end) begin
          tick_next = 32'h0;
          errs_next = 16'h0;
          blink_next = !blink_reg;
          class_next = (!prbs_locked || errs_reg >= LBT_CONT_ERRS) ? 2'h2 :
                       (errs_reg != 16'h0) ? 2'h1 : 2'h0; // [RQ14]
        end
      end
      default: begin
        lamp_next = LBT_LAMP_IDLE;
      end
    endcase
    if (!pattern_test_button_s) begin
      lamp_next = LBT_LAMP_IDLE;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      lamp_reg <= LBT_LAMP_IDLE;
      tick_reg <= 32'h0;
      errs_reg <= 16'h0;
      class_reg <= 2'h0;
      blink_reg <= 1'b0;
    end else begin
      lamp_reg <= lamp_next;
      tick_reg <= tick_next;
      errs_reg <= errs_next;
      class_reg <= class_next;
      blink_reg <= blink_next;
    end
  end
  wire logic err_lamp_next;
  assign err_lamp_next = (lamp_reg == LBT_LAMP_FLASH) ||
                         (lamp_reg == LBT_LAMP_RUN &&
                          (class_reg == 2'h2 ||
                           (class_reg == 2'h1 && blink_reg))); // [RQ10]

  // ----------------------------------------------------------------
  // Data path and terminal outputs
  // ----------------------------------------------------------------
  wire logic tx_data_next, tx_clock_next;
  assign tx_data_next = (path_next == LBT_PATH_DIGITAL) ? line_rx_data :
                        pattern_test_button_s ? prbs_tx : dte_tx_data; // [RQ12] [RQ2]
  assign tx_clock_next = (path_next == LBT_PATH_DIGITAL) ? line_rx_clock :
                         dte_tx_clock; // [RQ12]
  wire logic dcd_next;
  assign dcd_next = rts_ok &&
                    (path_next == LBT_PATH_ANALOG || valid_s); // [RQ4] [RQ5]
  wire logic test_next;
  assign test_next = path_next != LBT_PATH_NORMAL || want_far; // [RQ4] [RQ7]

  always_ff @(posedge clock) begin
    if (reset) begin
      line_tx_data <= 1'b0;
      line_tx_clock <= 1'b0;
      analog_loop <= 1'b0;
      peer_loop_signal <= 1'b0;
      dte_rx_data <= 1'b0;
      clear_to_send <= 1'b0;
      data_set_ready <= 1'b0;
      carrier_detect <= 1'b0;
      test_lamp <= 1'b0;
      carrier_lamp <= 1'b0;
      error_lamp <= 1'b0;
    end else begin
      line_tx_data <= tx_data_next;
      line_tx_clock <= tx_clock_next;
      analog_loop <= path_next == LBT_PATH_ANALOG; // [RQ3]
      peer_loop_signal <= want_far || want_near; // [RQ6] [RQ8]
      dte_rx_data <= !pattern_test_button_s && line_rx_data; // [RQ13] [RQ2]
      clear_to_send <= !pattern_test_button_s && rts_s; // [RQ13]
      data_set_ready <= path_next != LBT_PATH_DIGITAL &&
                        !want_far; // [RQ12]
      carrier_detect <= dcd_next; // [RQ5]
      test_lamp <= test_next; // [RQ7]
      carrier_lamp <= dcd_next; // [RQ4]
      error_lamp <= err_lamp_next;
    end
  end
endmodule : lbt_loop_ctrl
`default_nettype wire

// [dv/lbt_loop_ctrl_assertions.sv]
/* Checker for the loop control ports.
   Assumes pins are held steady over several clocks. */
`timescale 1ns/100ps
`default_nettype none
module lbt_loop_ctrl_assertions
  import lbt_pkg::*;
#(
  parameter int unsigned FLASH_CYC = 50,
  parameter int unsigned WINDOW_CYC = 400
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic pattern_test_button,
  input wire logic local_line_loop_button,
  input wire logic far_loop_button,
  input wire logic near_echo_loop_button,
  input wire logic remote_loop_request,
  input wire logic remote_loop_enable,
  input wire logic carrier_force,
  input wire logic request_to_send,
  input wire logic peer_loop_request,
  input wire logic line_rx_data,
  input wire logic line_tx_data,
  input wire logic line_rx_clock,
  input wire logic line_tx_clock,
  input wire logic analog_loop,
  input wire logic peer_loop_signal,
  input wire logic dte_rx_data,
  input wire logic clear_to_send,
  input wire logic data_set_ready,
  input wire logic carrier_detect,
  input wire logic test_lamp,
  input wire logic carrier_lamp,
  input wire logic error_lamp
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_pat_idle; !pattern_test_button [*4]; endsequence
  sequence s_pat_held; pattern_test_button [*5]; endsequence
  a_pat_quiet: assert property (
    s_pat_held |-> !clear_to_send && !dte_rx_data) else $error("cts on");
  a_cts_rts: assert property (
    (!pattern_test_button && request_to_send) [*5] |-> clear_to_send)
    else $error("cts off");
  a_lamp_check: assert property (
    s_pat_idle ##1 s_pat_held ##1 s_pat_held |-> error_lamp)
    else $error("no lamp flash");
  a_dcd_off: assert property (
    (!carrier_force && !request_to_send) [*4] |->
      !carrier_detect && !carrier_lamp) else $error("carrier on");
  a_analog_on: assert property (
    (local_line_loop_button && carrier_force && !near_echo_loop_button &&
      !peer_loop_request) [*5] |-> analog_loop && test_lamp &&
      carrier_detect && carrier_lamp) else $error("analog loop off");
  a_far_loop: assert property (
    far_loop_button [*4] |-> peer_loop_signal && test_lamp &&
      !data_set_ready) else $error("far loop off");
  a_remote_req: assert property (
    (remote_loop_request && remote_loop_enable) [*4] |-> peer_loop_signal)
    else $error("remote request lost");
  a_near_echo: assert property (
    near_echo_loop_button [*4] |-> peer_loop_signal && test_lamp &&
      !data_set_ready && !analog_loop) else $error("near loop off");
  a_echo_data: assert property (
    near_echo_loop_button [*5] |-> line_tx_data == $past(line_rx_data))
    else $error("echo data wrong");
  a_echo_clock: assert property (
    near_echo_loop_button [*5] |-> line_tx_clock == $past(line_rx_clock))
    else $error("echo clock wrong");
  a_rx_pass: assert property (
    !pattern_test_button [*4] |-> dte_rx_data == $past(line_rx_data))
    else $error("receive data wrong");
endmodule : lbt_loop_ctrl_assertions

bind lbt_loop_ctrl lbt_loop_ctrl_assertions #(
  .FLASH_CYC(FLASH_CYC),
  .WINDOW_CYC(WINDOW_CYC)
) i_lbt_loop_ctrl_assertions (.clock, .reset, .pattern_test_button,
  .local_line_loop_button, .far_loop_button, .near_echo_loop_button,
  .remote_loop_request, .remote_loop_enable, .carrier_force,
  .request_to_send, .peer_loop_request, .line_rx_data, .line_tx_data,
  .line_rx_clock, .line_tx_clock,
  .analog_loop, .peer_loop_signal, .dte_rx_data, .clear_to_send,
  .data_set_ready, .carrier_detect, .test_lamp, .carrier_lamp,
  .error_lamp);
`default_nettype wire

// [dv/lbt_peer_model.sv]
/* Peer line modem: bit strobe, line clock, loop of our bits.
   Assumes the card's line outputs are registered on clock. */
`timescale 1ns/100ps
`default_nettype none
module lbt_peer_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic line_tx_data,
  input wire logic loop_back,
  input wire logic peer_loop_signal,
  input wire logic corrupt,
  output logic bit_strobe,
  output logic line_rx_data,
  output logic line_rx_clock,
  output logic peer_test_lamp
);
  logic [2:0] phase_reg;
  logic idle_reg;
  always_ff @(posedge clock) begin
    phase_reg <= reset ? 3'h0 : phase_reg + 3'h1;
    idle_reg <= reset ? 1'b0 : ~idle_reg;
  end
  assign bit_strobe = (phase_reg == 3'h7);
  assign line_rx_clock = phase_reg[2];
  // Looped bits come back, flipped where corrupt; else a toggling line
  assign line_rx_data = (loop_back | peer_loop_signal) ?
    (line_tx_data ^ corrupt) : idle_reg;
  assign peer_test_lamp = peer_loop_signal;
endmodule : lbt_peer_model
`default_nettype wire

// [dv/lbt_loop_ctrl_test.sv]
/* Testbench for the loop control block with a peer model.
   Assumes short lamp timing parameters. */
`timescale 1ns/100ps
`default_nettype none
module lbt_loop_ctrl_test;
  import lbt_pkg::*;
  localparam int unsigned FLASH = 50;
  localparam int unsigned WIN = 400;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [10:0] pins = 11'h000;
  logic corrupt = 1'b0, noisy = 1'b1, bad = 1'b0, chk = 1'b0;
  logic dte_tx_data = 1'b0, dte_tx_clock = 1'b0;
  logic line_signal_valid = 1'b1;
  logic line_tx_data, line_tx_clock, analog_loop, peer_loop_signal;
  logic dte_rx_data, clear_to_send, data_set_ready, carrier_detect;
  logic test_lamp, carrier_lamp, error_lamp;
  logic bit_strobe, line_rx_data, line_rx_clock;
  logic [7:0] q[$];
  logic [7:0] got, want;
  int err_total = 0, checks = 0;
  wire pattern_test_button = pins[10], local_line_loop_button = pins[9];
  wire far_loop_button = pins[8], near_echo_loop_button = pins[7];
  wire local_loop_request = pins[6], remote_loop_request = pins[5];
  wire local_loop_enable = pins[4], remote_loop_enable = pins[3];
  wire carrier_force = pins[2], request_to_send = pins[1];
  wire peer_loop_request = pins[0];
  wire [7:0] seen = {analog_loop, peer_loop_signal, clear_to_send,
    data_set_ready, carrier_detect, test_lamp, carrier_lamp, error_lamp};
  always #5 clock = ~clock;
  lbt_loop_ctrl #(.FLASH_CYC(FLASH), .WINDOW_CYC(WIN)) i_lbt_loop_ctrl (
    .clock, .reset, .pattern_test_button, .local_line_loop_button,
    .far_loop_button, .near_echo_loop_button, .local_loop_request,
    .remote_loop_request, .local_loop_enable, .remote_loop_enable,
    .carrier_force, .request_to_send, .peer_loop_request,
    .line_signal_valid, .bit_strobe, .line_rx_data, .line_rx_clock,
    .dte_tx_data, .dte_tx_clock, .line_tx_data, .line_tx_clock,
    .analog_loop, .peer_loop_signal, .dte_rx_data, .clear_to_send,
    .data_set_ready, .carrier_detect, .test_lamp, .carrier_lamp,
    .error_lamp);
  lbt_peer_model i_lbt_peer_model (.clock, .reset, .line_tx_data,
    .loop_back(analog_loop), .peer_loop_signal, .corrupt, .bit_strobe,
    .line_rx_data, .line_rx_clock, .peer_test_lamp());
  // -------------------------------------------------
  // Random line noise and terminal data
  // -------------------------------------------------
  always @(posedge clock) begin
    corrupt <= noisy ? 1'($urandom) : bad;
    dte_tx_data <= 1'($urandom);
    dte_tx_clock <= 1'($urandom);
  end
  always @(posedge clock) begin
    if (chk) begin
      got = seen;
      want = q.pop_front();
      checks++;
      if (got !== want) begin
        $display("wrong value at %0t: got %h want %h", $time, got, want);
        err_total++;
      end
    end
  end
  task print_verdict;
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  task expect_now(input logic [7:0] e);
    q.push_back(e);
    chk <= 1'b1;
    @(posedge clock);
    chk <= 1'b0;
  endtask : expect_now
  task run_row(input logic [10:0] p, input logic [7:0] e);
    pins <= p;
    wait_cyc(8);
    expect_now(e);
  endtask : run_row
  // Pattern test over the analog loop; line forced on; every bit flipped from the start if b, random noise after lock if n
  task pattern_error_tester(input logic b, input logic n, input logic [7:0] e);
    @(posedge clock);
    noisy <= 1'b0;
    bad <= b;
    run_row(11'h606, 8'h9F);
    wait_cyc(FLASH + WIN);
    noisy <= n;
    wait_cyc(2 * WIN);
    expect_now(e);
    wait_cyc(WIN);
    expect_now(e ^ {7'h0, n});
    noisy <= 1'b1;
    run_row(11'h006, 8'h3A);
  endtask : pattern_error_tester
  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    void'($urandom(32'hBDCF));
    wait_cyc(6);
    reset <= 1'b0;
    run_row(11'h006, 8'h3A);
    run_row(11'h004, 8'h1A);
    run_row(11'h206, 8'hBE);
    line_signal_valid <= 1'b0;
    run_row(11'h206, 8'hBE);
    run_row(11'h006, 8'h30);
    line_signal_valid <= 1'b1;
    run_row(11'h056, 8'hBE);
    run_row(11'h046, 8'h3A);
    run_row(11'h200, 8'h94);
    run_row(11'h106, 8'h6E);
    run_row(11'h02E, 8'h6E);
    run_row(11'h026, 8'h3A);
    run_row(11'h086, 8'h6E);
    run_row(11'h286, 8'h6E);
    run_row(11'h007, 8'h2E);
    run_row(11'h406, 8'h1B);
    pattern_error_tester(1'b0, 1'b0, 8'h9E);
    pattern_error_tester(1'b1, 1'b0, 8'h9F);
    pattern_error_tester(1'b0, 1'b1, 8'h9F);
    wait_cyc(2);
    print_verdict;
  end
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
endmodule : lbt_loop_ctrl_test
`default_nettype wire
